// ---- inc/flash_sec_pkg.sv ----
// constants shared by the flash option and security configuration block
`default_nettype none
package flash_sec_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PULSE_MIN_NS  = 5000;
  localparam int unsigned PULSE_MAX_NS  = 6700;
  // least time rounds up, longest time rounds down
  localparam logic [9:0] PULSE_MIN_CYC =
    10'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] PULSE_MAX_CYC = 10'(PULSE_MAX_NS / CLK_PERIOD_NS);

  localparam logic [7:0] OFS_RATIO   = 8'h00;
  localparam logic [7:0] OFS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;

  localparam int unsigned RATIO_LOADED_BIT = 7;
  localparam int unsigned PRESCALE_BIT     = 6;
  localparam int unsigned OPT_BACKDOOR_ALLOW_BIT    = 7;
  localparam int unsigned OPT_NORED_BIT    = 6;
  localparam int unsigned CFG_KEY_COMPARE_ACCESS_BIT   = 5;
  localparam int unsigned CFG_RANGE_BIT    = 0;

  localparam logic [5:0]  DIVISOR_RST   = 6'h00;
  localparam logic [1:0]  SEC_UNSECURED = 2'h2;
  localparam logic [1:0]  SEC_RST       = 2'h3;
  localparam logic [2:0]  PRESCALE_LAST = 3'h7;
  localparam int unsigned PRESCALE_SHIFT = 3;
  localparam logic [15:0] KEY_BASE      = 16'hffb0;
  localparam int unsigned KEY_BYTES     = 8;
  localparam logic [3:0]  KEY_FULL      = 4'h8;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_RUN  = 2'h1
  } mode_type;
endpackage
`default_nettype wire

// ---- rtl/flash_option_security_config.sv ----
// flash clock ratio, options shadow, key access and security state
// Operation
// - flash clock period is divisor plus one bus clocks, times eight if prescaled.
// - options shadow is loaded from the nonvolatile copy on every reset.
// - backdoor allow clear means no key comparison can unlock.
// - only firmware writes supply key values; debug writes never do.
// - eight ascending key bytes matching the stored key unlock until reset.
// - redirect-off bit set disables vector redirection, clear enables it.
// - security code 1:0 alone means unsecured; all others secure.
// - while secure, debug access to memory is blocked.
// - key match or full blank check sets security code to 1:0.
// - key-access clear: key location writes start a flash command.
// - key-access set: key location writes are captured for comparison.
// - ratio bits write once after reset; first write sets loaded flag.
// - clearing key-access after eighth write compares and may unlock.
// - no program or erase until the ratio register was written.
`default_nettype none
module flash_option_security_config (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  nonvolatile_options,
  input  wire logic [63:0] stored_backdoor_key,
  input  wire logic        mem_wr_strobe,
  input  wire logic [15:0] mem_wr_addr,
  input  wire logic [7:0]  mem_wr_data,
  input  wire logic        mem_wr_from_debug,
  input  wire logic        blank_check_pass,
  input  wire logic        dbg_mem_req,
  output logic             dbg_mem_grant,
  output logic             flash_clk_tick,
  output logic             cmd_start,
  output logic             cmd_refused,
  output logic             security_engaged,
  output logic             vector_redirect_off,
  output logic             options_valid
);
  flash_sec_pkg::mode_type state_reg, state_next;
  logic        ratio_loaded_flag_reg, ratio_loaded_flag_next;
  logic        prescale_by_eight_reg, prescale_by_eight_next;
  logic [5:0]  divisor_reg, divisor_next;
  logic        backdoor_allow_reg, backdoor_allow_next;
  logic        redirect_off_reg, redirect_off_next;
  logic [1:0]  security_code_reg, security_code_next;
  logic        key_compare_access_reg, key_compare_access_next;
  logic        in_range_reg, in_range_next;
  logic [3:0]  key_cnt_reg, key_cnt_next;
  logic [7:0]  key_buf_reg [flash_sec_pkg::KEY_BYTES];
  logic [7:0]  key_buf_next [flash_sec_pkg::KEY_BYTES];
  logic [2:0]  pre_cnt_reg, pre_cnt_next;
  logic [5:0]  div_cnt_reg, div_cnt_next;
  logic        tick_reg, tick_next;
  logic        cmd_start_reg, cmd_start_next;
  logic        cmd_refused_reg, cmd_refused_next;
  logic        secure_reg, secure_next;
  logic        grant_reg, grant_next;
  logic        valid_reg, valid_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        apb_access, wr_commit, cfg_commit, ratio_commit, running;
  logic        key_hit, key_accept, in_order, stage_tick;
  logic [2:0]  key_ofs;
  logic [9:0]  div_plus_one, period_cyc;
  logic [flash_sec_pkg::KEY_BYTES-1:0] byte_match;
  logic [7:0]  options_view, config_view, ratio_view;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  assign running      = (state_reg == flash_sec_pkg::ST_RUN);
  // two-cycle access phase so read data leaves a flop
  assign apb_access   = psel & penable & ~pready_reg;
  assign wr_commit    = psel & penable & pready_reg & pwrite;
  assign ratio_commit = wr_commit & (paddr == flash_sec_pkg::OFS_RATIO);
  assign cfg_commit   = wr_commit & (paddr == flash_sec_pkg::OFS_CONFIG);
  assign key_hit      = mem_wr_strobe & running &
                        (mem_wr_addr[15:3] == flash_sec_pkg::KEY_BASE[15:3]);
  assign key_ofs      = mem_wr_addr[2:0];
  assign key_accept   = key_hit & key_compare_access_reg & backdoor_allow_reg
                        & ~mem_wr_from_debug;
  assign in_order     = (key_cnt_reg < flash_sec_pkg::KEY_FULL) &
                        (key_ofs == key_cnt_reg[2:0]);

  assign ratio_view   = {ratio_loaded_flag_reg, prescale_by_eight_reg, divisor_reg};
  assign options_view = {backdoor_allow_reg, redirect_off_reg, 4'h0,
                         security_code_reg};
  assign config_view  = {2'h0, key_compare_access_reg, 4'h0, in_range_reg};

  genvar gi;
  generate
    for (gi = 0; gi < flash_sec_pkg::KEY_BYTES; gi++) begin : g_cmp
      assign byte_match[gi] = (key_buf_reg[gi] == stored_backdoor_key[gi*8 +: 8]);
    end
  endgenerate

  assign div_plus_one = {4'h0, divisor_reg} + 10'h001;
  assign period_cyc   = prescale_by_eight_reg ?
                        (div_plus_one << flash_sec_pkg::PRESCALE_SHIFT) : div_plus_one;
  assign stage_tick   = ~prescale_by_eight_reg |
                        (pre_cnt_reg == flash_sec_pkg::PRESCALE_LAST);

  always_comb begin
    state_next              = state_reg;
    ratio_loaded_flag_next  = ratio_loaded_flag_reg;
    prescale_by_eight_next  = prescale_by_eight_reg;
    divisor_next            = divisor_reg;
    backdoor_allow_next     = backdoor_allow_reg;
    redirect_off_next       = redirect_off_reg;
    security_code_next      = security_code_reg;
    key_compare_access_next = key_compare_access_reg;
    key_cnt_next            = key_cnt_reg;
    key_buf_next            = key_buf_reg;
    cmd_start_next          = 1'b0;
    cmd_refused_next        = 1'b0;
    case (state_reg)
      flash_sec_pkg::ST_LOAD: begin
        // nonvolatile copy taken on the first edge after reset release
        backdoor_allow_next = nonvolatile_options[flash_sec_pkg::OPT_BACKDOOR_ALLOW_BIT];
        redirect_off_next   = nonvolatile_options[flash_sec_pkg::OPT_NORED_BIT];
        security_code_next  = nonvolatile_options[1:0];
        state_next          = flash_sec_pkg::ST_RUN;
      end
      flash_sec_pkg::ST_RUN: begin
        if (ratio_commit && !ratio_loaded_flag_reg) begin
          ratio_loaded_flag_next = 1'b1;
          prescale_by_eight_next = pwdata[flash_sec_pkg::PRESCALE_BIT];
          divisor_next           = pwdata[5:0];
        end
        if (key_accept) begin
          if (in_order) begin
            key_buf_next[key_ofs] = mem_wr_data;
            key_cnt_next          = key_cnt_reg + 4'h1;
          end else begin
            key_cnt_next = 4'h0;
          end
        end
        if (key_hit && !key_compare_access_reg) begin
          cmd_start_next   = ratio_loaded_flag_reg;
          cmd_refused_next = ~ratio_loaded_flag_reg;
        end
        if (cfg_commit) begin
          key_compare_access_next = pwdata[flash_sec_pkg::CFG_KEY_COMPARE_ACCESS_BIT];
          if (key_compare_access_reg != pwdata[flash_sec_pkg::CFG_KEY_COMPARE_ACCESS_BIT]) begin
            key_cnt_next = 4'h0;
          end
          if (key_compare_access_reg && !pwdata[flash_sec_pkg::CFG_KEY_COMPARE_ACCESS_BIT] &&
              backdoor_allow_reg && (key_cnt_reg == flash_sec_pkg::KEY_FULL) &&
              (&byte_match)) begin
            security_code_next = flash_sec_pkg::SEC_UNSECURED;
          end
        end
        if (blank_check_pass) begin
          security_code_next = flash_sec_pkg::SEC_UNSECURED;
        end
      end
      default: state_next = flash_sec_pkg::ST_LOAD;
    endcase
  end

  always_comb begin
    pre_cnt_next = pre_cnt_reg;
    div_cnt_next = div_cnt_reg;
    tick_next    = 1'b0;
    // divider stays idle until software sets the ratio
    if (ratio_loaded_flag_reg) begin
      pre_cnt_next = prescale_by_eight_reg ? pre_cnt_reg + 3'h1 : 3'h0;
      if (stage_tick) begin
        tick_next    = (div_cnt_reg == divisor_reg);
        div_cnt_next = tick_next ? 6'h00 : div_cnt_reg + 6'h01;
      end
    end
  end

  always_comb begin
    // software sees whether its ratio gives a legal pulse width
    in_range_next = (period_cyc >= flash_sec_pkg::PULSE_MIN_CYC) &&
                    (period_cyc <= flash_sec_pkg::PULSE_MAX_CYC);
    secure_next   = (security_code_next != flash_sec_pkg::SEC_UNSECURED);
    grant_next    = dbg_mem_req & ~secure_reg & running;
    valid_next    = (state_next == flash_sec_pkg::ST_RUN);
    pready_next   = apb_access;
    prdata_next   = 32'h0000_0000;
    pslverr_next  = 1'b0;
    if (apb_access && !pwrite) begin
      case (paddr)
        flash_sec_pkg::OFS_RATIO:   prdata_next = {24'h000000, ratio_view};
        flash_sec_pkg::OFS_OPTIONS: prdata_next = {24'h000000, options_view};
        flash_sec_pkg::OFS_CONFIG:  prdata_next = {24'h000000, config_view};
        default:                    pslverr_next = 1'b1;
      endcase
    end else if (apb_access) begin
      // options write is accepted without error but changes nothing
      pslverr_next = (paddr != flash_sec_pkg::OFS_RATIO) &&
                     (paddr != flash_sec_pkg::OFS_OPTIONS) &&
                     (paddr != flash_sec_pkg::OFS_CONFIG);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg              <= flash_sec_pkg::ST_LOAD;
      ratio_loaded_flag_reg  <= 1'b0;
      prescale_by_eight_reg  <= 1'b0;
      divisor_reg            <= flash_sec_pkg::DIVISOR_RST;
      backdoor_allow_reg     <= 1'b0;
      redirect_off_reg       <= 1'b0;
      security_code_reg      <= flash_sec_pkg::SEC_RST;
      key_compare_access_reg <= 1'b0;
      key_cnt_reg            <= 4'h0;
      for (int i = 0; i < flash_sec_pkg::KEY_BYTES; i++) begin
        key_buf_reg[i] <= 8'h00;
      end
      pre_cnt_reg      <= 3'h0;
      div_cnt_reg      <= 6'h00;
      tick_reg         <= 1'b0;
      cmd_start_reg    <= 1'b0;
      cmd_refused_reg  <= 1'b0;
      in_range_reg     <= 1'b0;
      secure_reg       <= 1'b1;
      grant_reg        <= 1'b0;
      valid_reg        <= 1'b0;
      prdata_reg       <= 32'h0000_0000;
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
    end else begin
      state_reg              <= state_next;
      ratio_loaded_flag_reg  <= ratio_loaded_flag_next;
      prescale_by_eight_reg  <= prescale_by_eight_next;
      divisor_reg            <= divisor_next;
      backdoor_allow_reg     <= backdoor_allow_next;
      redirect_off_reg       <= redirect_off_next;
      security_code_reg      <= security_code_next;
      key_compare_access_reg <= key_compare_access_next;
      key_cnt_reg            <= key_cnt_next;
      key_buf_reg            <= key_buf_next;
      pre_cnt_reg      <= pre_cnt_next;
      div_cnt_reg      <= div_cnt_next;
      tick_reg         <= tick_next;
      cmd_start_reg    <= cmd_start_next;
      cmd_refused_reg  <= cmd_refused_next;
      in_range_reg     <= in_range_next;
      secure_reg       <= secure_next;
      grant_reg        <= grant_next;
      valid_reg        <= valid_next;
      prdata_reg       <= prdata_next;
      pready_reg       <= pready_next;
      pslverr_reg      <= pslverr_next;
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign dbg_mem_grant       = grant_reg;
  assign flash_clk_tick      = tick_reg;
  assign cmd_start           = cmd_start_reg;
  assign cmd_refused         = cmd_refused_reg;
  assign security_engaged    = secure_reg;
  assign vector_redirect_off = redirect_off_reg;
  assign options_valid       = valid_reg;

  // helper: cycles since the previous flash clock tick
  logic [9:0] gap_reg;
  logic       seen_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_reg  <= 10'h000;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= tick_reg ? 10'h001 : gap_reg + 10'h001;
      seen_reg <= seen_reg | tick_reg;
    end
  end

  AST_TICK_PERIOD: assert property (tick_reg && seen_reg |-> gap_reg == period_cyc)
    else $error("flash clock period differs from ratio setting");
  // keyed on the edge after the load edge; the load edge itself still shows the reset values
  AST_LOAD_SHADOW: assert property ($past(state_reg) == flash_sec_pkg::ST_LOAD &&
      state_reg == flash_sec_pkg::ST_RUN |->
      security_code_reg == $past(nonvolatile_options[1:0]) &&
      backdoor_allow_reg == $past(nonvolatile_options[flash_sec_pkg::OPT_BACKDOOR_ALLOW_BIT]) &&
      redirect_off_reg == $past(nonvolatile_options[flash_sec_pkg::OPT_NORED_BIT]))
    else $error("options shadow not loaded from nonvolatile copy");
  AST_RATIO_ONCE: assert property (ratio_loaded_flag_reg |=>
      ratio_loaded_flag_reg && $stable({prescale_by_eight_reg, divisor_reg}))
    else $error("ratio changed after first write");
  AST_RATIO_FIRST: assert property (ratio_commit && !ratio_loaded_flag_reg && running |=>
      ratio_loaded_flag_reg && divisor_reg == $past(pwdata[5:0]))
    else $error("first ratio write not taken");
  AST_CMD_INHIBIT: assert property (cmd_start_reg |-> $past(ratio_loaded_flag_reg))
    else $error("command started before ratio was written");
  AST_CMD_ROUTE: assert property (key_hit && !key_compare_access_reg |=>
      cmd_start_reg != cmd_refused_reg)
    else $error("key location write not routed to command");
  AST_KEY_ROUTE: assert property (key_hit && key_compare_access_reg |=>
      !cmd_start_reg && !cmd_refused_reg)
    else $error("key compare write started a command");
  AST_DEBUG_NOKEY: assert property (key_hit && mem_wr_from_debug && !cfg_commit |=>
      $stable(key_cnt_reg))
    else $error("debug write captured as key value");
  AST_BACKDOOR_ALLOW_LOCK: assert property (running && $past(running) && $fell(secure_reg) &&
      !$past(backdoor_allow_reg) |-> $past(blank_check_pass))
    else $error("unlocked by key while backdoor disallowed");
  AST_KEY_UNLOCK: assert property (cfg_commit && running && key_compare_access_reg &&
      !pwdata[flash_sec_pkg::CFG_KEY_COMPARE_ACCESS_BIT] && backdoor_allow_reg &&
      key_cnt_reg == flash_sec_pkg::KEY_FULL && (&byte_match) |=>
      security_code_reg == flash_sec_pkg::SEC_UNSECURED ##1 !secure_reg)
    else $error("matching key did not unlock");
  AST_BLANK_UNSEC: assert property (blank_check_pass && running |=> ##1 !secure_reg)
    else $error("blank check did not unlock");
  // both flops load from the same next value, so they must agree on every edge
  AST_SEC_DECODE: assert property (secure_reg ==
      (security_code_reg != flash_sec_pkg::SEC_UNSECURED))
    else $error("security decode wrong");
  AST_DEBUG_BLOCK: assert property (grant_reg |-> !$past(secure_reg))
    else $error("debug access granted while secure");
  AST_ORDER: assert property (key_accept && !in_order && !cfg_commit && running |=>
      key_cnt_reg == 4'h0)
    else $error("out of order key write kept");

  COV_KEY_UNLOCK: cover property (key_compare_access_reg ##1 $fell(secure_reg));
  COV_BLANK: cover property (blank_check_pass ##2 !secure_reg);
  COV_CMD: cover property (cmd_start_reg);
  COV_REFUSED: cover property (cmd_refused_reg);
endmodule
`default_nettype wire

// ---- dv/flash_option_security_config_tb_top.sv ----
// self-checking bench for the flash option and security configuration block
`default_nettype none
module flash_option_security_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, psel, penable, pwrite, mem_wr_strobe, mem_wr_from_debug;
  logic        blank_check_pass, dbg_mem_req, pready, pslverr, dbg_mem_grant, flash_clk_tick;
  logic        cmd_start, cmd_refused, security_engaged, vector_redirect_off, options_valid;
  logic [7:0]  paddr, nonvolatile_options, mem_wr_data;
  logic [15:0] mem_wr_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] stored_backdoor_key;
  logic        err, st, rf;
  int          n_mismatch, samples_checked;

  flash_option_security_config dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nonvolatile_options(nonvolatile_options),
    .stored_backdoor_key(stored_backdoor_key), .mem_wr_strobe(mem_wr_strobe),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_wr_from_debug(mem_wr_from_debug), .blank_check_pass(blank_check_pass),
    .dbg_mem_req(dbg_mem_req), .dbg_mem_grant(dbg_mem_grant),
    .flash_clk_tick(flash_clk_tick), .cmd_start(cmd_start), .cmd_refused(cmd_refused),
    .security_engaged(security_engaged), .vector_redirect_off(vector_redirect_off),
    .options_valid(options_valid));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // one apb transfer; answer taken at the edge that sees pready high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    bound(n, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mw(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    @(posedge clk_sys);
    mem_wr_strobe <= 1'b1;
    mem_wr_addr <= a;
    mem_wr_data <= d;
    mem_wr_from_debug <= dbg;
    @(posedge clk_sys);
    mem_wr_strobe <= 1'b0;
    #1;
    st = cmd_start;
    rf = cmd_refused;
  endtask

  // key entry; skip < 8 leaves one byte out to break the ascending order
  task automatic unlock(input int skip, input logic dbg);
    apb(1'b1, flash_sec_pkg::OFS_CONFIG, 32'h0000_0020);
    for (int k = 0; k < 8; k++) begin
      if (k != skip) begin
        mw(flash_sec_pkg::KEY_BASE + 16'(k), stored_backdoor_key[k*8 +: 8], dbg);
        chk({30'h0, st, rf}, 32'h0);
      end
    end
    apb(1'b1, flash_sec_pkg::OFS_CONFIG, 32'h0000_0000);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic tick_period(input int exp);
    int n;
    // step off the edge so a tick launched on it is not counted early
    #1;
    n = 0;
    while (flash_clk_tick !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    bound(n, 300);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (flash_clk_tick !== 1'b1 && n < 300);
    chk(32'(n), 32'(exp));
  endtask

  task automatic do_reset(input logic [7:0] nv);
    @(posedge clk_sys);
    rst <= 1'b1;
    nonvolatile_options <= nv;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    {psel, penable, pwrite, mem_wr_strobe, mem_wr_from_debug, blank_check_pass} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_wr_addr = 16'h0000;
    mem_wr_data = 8'h00;
    dbg_mem_req = 1'b1;
    stored_backdoor_key = 64'h0123_4567_89ab_cdef;
    do_reset(8'hc1);
    chk({29'h0, options_valid, vector_redirect_off, security_engaged}, 32'h7);
    apb(1'b0, flash_sec_pkg::OFS_OPTIONS, 32'h0);
    chk(rd, 32'h0000_00c1);
    // shadow keeps its value when the nonvolatile copy changes without a reset
    nonvolatile_options <= 8'h02;
    apb(1'b1, flash_sec_pkg::OFS_OPTIONS, 32'h0000_00ff);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, flash_sec_pkg::OFS_OPTIONS, 32'h0);
    chk(rd, 32'h0000_00c1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    mw(flash_sec_pkg::KEY_BASE, 8'h55, 1'b0);
    chk({30'h0, st, rf}, 32'h1);
    apb(1'b1, flash_sec_pkg::OFS_RATIO, 32'h0000_0005);
    apb(1'b1, flash_sec_pkg::OFS_RATIO, 32'h0000_007f);
    apb(1'b0, flash_sec_pkg::OFS_RATIO, 32'h0);
    chk(rd, 32'h0000_0085);
    tick_period(6);
    apb(1'b0, flash_sec_pkg::OFS_CONFIG, 32'h0);
    chk(rd, 32'h0000_0000);
    mw(flash_sec_pkg::KEY_BASE + 16'h0007, 8'h55, 1'b0);
    chk({30'h0, st, rf}, 32'h2);
    chk({31'h0, dbg_mem_grant}, 32'h0);
    unlock(8, 1'b1);
    chk({31'h0, security_engaged}, 32'h1);
    unlock(2, 1'b0);
    chk({31'h0, security_engaged}, 32'h1);
    unlock(8, 1'b0);
    chk({31'h0, security_engaged}, 32'h0);
    @(posedge clk_sys);
    #1;
    chk({31'h0, dbg_mem_grant}, 32'h1);
    apb(1'b0, flash_sec_pkg::OFS_OPTIONS, 32'h0);
    chk(rd, 32'h0000_00c2);
    do_reset(8'h01);
    chk({30'h0, vector_redirect_off, security_engaged}, 32'h1);
    unlock(8, 1'b0);
    chk({31'h0, security_engaged}, 32'h1);
    @(posedge clk_sys);
    blank_check_pass <= 1'b1;
    @(posedge clk_sys);
    blank_check_pass <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({31'h0, security_engaged}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      do_reset(8'h80 | 8'(c));
      chk({31'h0, security_engaged}, {31'h0, c != 2});
      apb(1'b0, flash_sec_pkg::OFS_OPTIONS, 32'h0);
      chk(rd, 32'h80 | 32'(c));
    end
    apb(1'b1, flash_sec_pkg::OFS_RATIO, 32'h0000_004f);
    tick_period(128);
    apb(1'b0, flash_sec_pkg::OFS_CONFIG, 32'h0);
    chk(rd, 32'h0000_0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
